// [hw/scc_seconds_counter.v]
// Seconds counter with prescaler, alarm compare and interrupt.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "scc_defs.vh"

// ----------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------
// Operation
// R1 - Count increments once per prescaler period
// R2 - Period equals prescale value, zero means 65536
// R3 - Count wraps to zero after maximum
// R4 - Prescale 0x8000 gives one second
// R5 - Software should program prescale three or more
// R6 - Increment flag set each increment, kept
// R7 - Alarm flag set when count matches
// R8 - Compared value is alarm value plus one
// R9 - Alarm register resets to all ones
// R10 - Reading flags clears both flags
// R11 - Read clear acts two slow cycles later
// R12 - Interrupt from enabled alarm or increment flag
// R13 - Handler disables interrupt until flags clear
// R14 - Restart reloads prescaler and zeroes count
// R15 - Restart acts two slow cycles later
// R16 - Software reads count until two agree
// R17 - Flags: alarm bit zero, increment bit one
// R18 - Slow domain events synchronized before observation
module scc_seconds_counter (
    input  wire        SYS_CLK,   // System clock, 250 MHz
    input  wire        RESET,     // Asynchronous reset, active high
    input  wire        CLK_EN,    // Clock enable, freezes all state
    input  wire        SLOW_CLK,  // Slow clock pin, sampled
    input  wire [7:0]  ADDR,      // Register byte address
    input  wire [31:0] WR_DATA,   // Write data
    input  wire        WR_EN,     // Write strobe
    input  wire        RD_EN,     // Read strobe
    output reg  [31:0] RD_DATA,   // Read data, cycle after strobe
    output reg         IRQ        // Interrupt, level, active high
);

    // ------------------------------------------------------------------
    // Slow clock sampling
    // ------------------------------------------------------------------
    reg  [2:0]  slow_sync_q;
    wire        slow_tick;

    // R18 sync slow clock
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            slow_sync_q <= 3'h0;
        end else if (CLK_EN) begin
            slow_sync_q <= {slow_sync_q[1:0], SLOW_CLK};
        end
    end

    // The edge detector reads only the second and third stages.
    assign slow_tick = slow_sync_q[1] & ~slow_sync_q[2];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [15:0] pre_val_q;
    reg         alm_ien_q;
    reg         inc_ien_q;
    reg  [31:0] alarm_q;
    reg  [1:0]  irq_mask_q;
    reg  [31:0] count_q;
    reg  [15:0] div_q;
    reg         alarm_flag_q;
    reg         inc_flag_q;
    reg  [1:0]  rst_stage_q;
    reg  [1:0]  clr_stage_q;

    wire        wr_pre   = WR_EN && (ADDR == `SCC_OFF_PRESCALE);
    wire        wr_alarm = WR_EN && (ADDR == `SCC_OFF_ALARM);
    wire        wr_mask  = WR_EN && (ADDR == `SCC_OFF_IRQ_MASK);
    wire        rd_flags = RD_EN && (ADDR == `SCC_OFF_FLAGS);
    wire        wr_flags = WR_EN && (ADDR == `SCC_OFF_FLAGS);
    wire        restart_req = wr_pre && WR_DATA[`SCC_BIT_RESTART];
    wire        clr_req  = rd_flags ||
                           (wr_flags && (WR_DATA[1:0] != 2'h0));

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            // R4 one second default
            pre_val_q  <= `SCC_RST_PRESCALE;
            alm_ien_q  <= 1'b0;
            inc_ien_q  <= 1'b0;
            // R9 alarm resets high
            alarm_q    <= `SCC_RST_ALARM;
            irq_mask_q <= `SCC_RST_IRQ_MASK;
        end else if (CLK_EN) begin
            if (wr_pre) begin
                pre_val_q <= WR_DATA[`SCC_PRE_MSB:`SCC_PRE_LSB];
                alm_ien_q <= WR_DATA[`SCC_BIT_ALM_IEN];
                inc_ien_q <= WR_DATA[`SCC_BIT_INC_IEN];
            end
            if (wr_alarm) begin
                alarm_q <= WR_DATA;
            end
            if (wr_mask) begin
                irq_mask_q <= WR_DATA[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Delayed restart and flag clear
    // ------------------------------------------------------------------
    // A request arms a stage counter; the action happens on the second
    // slow clock edge after it. A new request restarts the wait.
    wire        restart_now = slow_tick && (rst_stage_q == `SCC_SLOW_DELAY);
    wire        clear_now   = slow_tick && (clr_stage_q == `SCC_SLOW_DELAY);

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            rst_stage_q <= 2'h0;
            clr_stage_q <= 2'h0;
        end else if (CLK_EN) begin
            // R15 restart delay
            if (restart_req) begin
                rst_stage_q <= 2'h1;
            end else if (restart_now) begin
                rst_stage_q <= 2'h0;
            end else if (slow_tick && (rst_stage_q != 2'h0)) begin
                rst_stage_q <= rst_stage_q + 2'h1;
            end
            // R11 clear delay
            if (clr_req) begin
                clr_stage_q <= 2'h1;
            end else if (clear_now) begin
                clr_stage_q <= 2'h0;
            end else if (slow_tick && (clr_stage_q != 2'h0)) begin
                clr_stage_q <= clr_stage_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    // R2 zero gives 65536
    wire [15:0] div_last  = pre_val_q - 16'h0001;
    wire        period_end = slow_tick && (div_q == div_last);
    // R3 wraps naturally
    wire [31:0] count_inc = count_q + 32'h00000001;
    // R8 compare plus one
    wire [31:0] alarm_cmp = alarm_q + 32'h00000001;

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            div_q   <= 16'h0000;
            count_q <= 32'h00000000;
        end else if (CLK_EN) begin
            // R14 reload and zero
            if (restart_now) begin
                div_q   <= 16'h0000;
                count_q <= 32'h00000000;
            // R1 count per period
            end else if (period_end) begin
                div_q   <= 16'h0000;
                count_q <= count_inc;
            end else if (slow_tick) begin
                div_q   <= div_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------------
    wire        inc_set = period_end && !restart_now;
    wire        alm_set = inc_set && (count_inc == alarm_cmp);

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            alarm_flag_q <= 1'b0;
            inc_flag_q   <= 1'b0;
        end else if (CLK_EN) begin
            // R6 increment flag
            if (inc_set) begin
                inc_flag_q <= 1'b1;
            // R10 read clears
            end else if (clear_now) begin
                inc_flag_q <= 1'b0;
            end
            // R7 alarm match
            if (alm_set) begin
                alarm_flag_q <= 1'b1;
            end else if (clear_now) begin
                alarm_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data and interrupt
    // ------------------------------------------------------------------
    reg  [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        case (ADDR)
            `SCC_OFF_PRESCALE: begin
                rd_mux[`SCC_PRE_MSB:`SCC_PRE_LSB] = pre_val_q;
                rd_mux[`SCC_BIT_ALM_IEN]          = alm_ien_q;
                rd_mux[`SCC_BIT_INC_IEN]          = inc_ien_q;
            end
            `SCC_OFF_ALARM: begin
                rd_mux = alarm_q;
            end
            `SCC_OFF_COUNT: begin
                rd_mux = count_q;
            end
            // R17 flag layout
            `SCC_OFF_FLAGS: begin
                rd_mux[`SCC_BIT_ALARM_FLAG] = alarm_flag_q;
                rd_mux[`SCC_BIT_INC_FLAG]   = inc_flag_q;
            end
            `SCC_OFF_IRQ_MASK: begin
                rd_mux[1:0] = irq_mask_q;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            RD_DATA <= 32'h00000000;
            IRQ     <= 1'b0;
        end else if (CLK_EN) begin
            RD_DATA <= RD_EN ? rd_mux : 32'h00000000;
            // R12 interrupt terms
            IRQ <= (alarm_flag_q & alm_ien_q & irq_mask_q[0]) |
                   (inc_flag_q & inc_ien_q & irq_mask_q[1]);
        end
    end

endmodule
`default_nettype wire

// [hw/scc_defs.vh]
// Register map, field positions and reset values of the seconds counter.
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SCC_ADDR_W           8
`define SCC_OFF_PRESCALE     8'h00
`define SCC_OFF_ALARM        8'h04
`define SCC_OFF_COUNT        8'h08
`define SCC_OFF_FLAGS        8'h0C
`define SCC_OFF_IRQ_MASK     8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCC_PRE_LSB          0
`define SCC_PRE_MSB          15
`define SCC_BIT_ALM_IEN      16
`define SCC_BIT_INC_IEN      17
`define SCC_BIT_RESTART      18
`define SCC_BIT_ALARM_FLAG   0
`define SCC_BIT_INC_FLAG     1

// ----------------------------------------------------------------------
// Reset values and delays
// ----------------------------------------------------------------------
`define SCC_RST_PRESCALE     16'h8000
`define SCC_RST_ALARM        32'hFFFFFFFF
`define SCC_RST_IRQ_MASK     2'h3
`define SCC_SLOW_DELAY       2'h2

`endif

// [tb/scc_seconds_counter_asserts.sv]
// Port checker for the seconds counter.
`timescale 1ns/1ns
`default_nettype none
module scc_seconds_counter_asserts (
    input wire        SYS_CLK,  // Clock
    input wire        RESET,    // Reset
    input wire        CLK_EN,   // Enable
    input wire        SLOW_CLK, // Slow clock
    input wire [7:0]  ADDR,     // Address
    input wire [31:0] WR_DATA,  // Write data
    input wire        WR_EN,    // Write strobe
    input wire        RD_EN,    // Read strobe
    input wire [31:0] RD_DATA,  // Read data
    input wire        IRQ       // Interrupt
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    logic alm_wr_q;
    wire  wp = WR_EN && ADDR == 8'h00;
    wire  rp = RD_EN && ADDR == 8'h00;
    wire  rc = RD_EN && ADDR == 8'h08;
    // Remembers whether the alarm word was written since reset.
    always @(posedge SYS_CLK or posedge RESET)
        if (RESET)
            alm_wr_q <= 1'b0;
        else if (WR_EN && ADDR == 8'h04)
            alm_wr_q <= 1'b1;
    a_alarm_reset_ones: assert property (
        RD_EN && ADDR == 8'h04 && !alm_wr_q |=> RD_DATA == 32'hFFFFFFFF)
        else $error("alarm reset value wrong");
    a_alarm_read_back: assert property (
        WR_EN && ADDR == 8'h04 ##1 RD_EN && ADDR == 8'h04
        |=> RD_DATA == $past(WR_DATA, 2)) else $error("alarm readback wrong");
    a_prescale_read_back: assert property (
        wp ##1 rp |=> RD_DATA[17:0] == $past(WR_DATA[17:0], 2))
        else $error("prescale readback wrong");
    a_restart_reads_zero: assert property (
        wp ##1 rp |=> !RD_DATA[18]) else $error("restart bit reads one");
    a_flags_upper_zero: assert property (
        RD_EN && ADDR == 8'h0C |=> RD_DATA[31:2] == 30'h0)
        else $error("flag word upper bits set");
    a_irq_enables_off: assert property (
        wp && WR_DATA[17:16] == 2'h0 |-> ##2 !IRQ)
        else $error("irq high with enables off");
    a_irq_mask_off: assert property (
        WR_EN && ADDR == 8'h10 && WR_DATA[1:0] == 2'h0 |-> ##2 !IRQ)
        else $error("irq high while masked");
    a_count_steps_one: assert property (
        rc ##1 rc |=> RD_DATA == $past(RD_DATA) || RD_DATA == 32'h0
        || RD_DATA == $past(RD_DATA) + 32'h1) else $error("count jumped");
    c_irq_rise: cover property ($rose(IRQ));
    c_count_twice: cover property (rc ##1 rc);
    c_restart: cover property (wp && WR_DATA[18]);
endmodule
`default_nettype wire

// [tb/scc_seconds_counter_tb.sv]
// Self-checking bench for the seconds counter.
`timescale 1ns/1ns
`default_nettype none
module scc_seconds_counter_tb;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        clk_en = 1'b1;
    logic        slow_clk = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        rd_q = 1'b0;
    wire  [31:0] rd_data;
    wire         irq;
    logic [63:0] exp_q[$];
    logic [31:0] alm;
    logic [31:0] p;
    int          errors = 0;
    int          check_count = 0;
    always #2 sys_clk = ~sys_clk;
    scc_seconds_counter i_dut (.SYS_CLK(sys_clk), .RESET(reset),
        .CLK_EN(clk_en), .SLOW_CLK(slow_clk), .ADDR(addr), .WR_DATA(wr_data),
        .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .IRQ(irq));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [63:0] ex);
        check_count++;
        if ((got & ex[63:32]) !== (ex[31:0] & ex[63:32])) begin
            errors++;
            $display("mismatch at %0t: read %h want %h", $time, got, ex[31:0]);
        end
    endtask
    // A read queues its expected word; a write is one strobe cycle.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d,
                       input logic [31:0] m = 32'hFFFFFFFF);
        if (!w)
            exp_q.push_back({m, d});
        addr <= a;
        wr_data <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge sys_clk);
    endtask
    task automatic idle;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic chk_irq(input logic ex);
        idle();
        @(negedge sys_clk);
        check_count++;
        if (irq !== ex) begin
            errors++;
            $display("mismatch at %0t: irq %b", $time, irq);
        end
        @(posedge sys_clk);
    endtask
    // Slow clock runs only here, so counts are still between calls.
    task automatic slow(input int n);
        idle();
        repeat (n) begin
            slow_clk <= 1'b1;
            repeat (8) @(posedge sys_clk);
            slow_clk <= 1'b0;
            repeat (8) @(posedge sys_clk);
        end
    endtask
    always @(posedge sys_clk)
        rd_q <= rd_en;
    always @(negedge sys_clk)
        if (rd_q)
            chk(rd_data, exp_q.pop_front());
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        p = $urandom(32'h4FAFC7D1);
        alm = $urandom();
        p = 32'h5 + $urandom_range(2);
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(0, 8'h00, 32'h8000, 32'h7FFFF);
        bus(0, 8'h04, 32'hFFFFFFFF);
        bus(0, 8'h08, 32'h0);
        bus(0, 8'h0C, 32'h0);
        bus(0, 8'h10, 32'h3, 32'h3);
        bus(0, 8'h14, 32'h0);
        bus(1, 8'h04, alm);
        bus(0, 8'h04, alm);
        bus(1, 8'h04, 32'h1);
        bus(1, 8'h00, 32'h0);
        bus(1, 8'h10, 32'h0);
        bus(1, 8'h10, 32'h3);
        bus(1, 8'h00, 32'h70000 | p);
        bus(0, 8'h00, 32'h30000 | p, 32'h7FFFF);
        slow(2);
        bus(0, 8'h08, 32'h0);
        slow(p);
        bus(0, 8'h08, 32'h1);
        bus(0, 8'h08, 32'h1);
        bus(0, 8'h0C, 32'h2);
        chk_irq(1'b1);
        slow(p);
        bus(0, 8'h0C, 32'h3);
        bus(0, 8'h0C, 32'h3);
        bus(1, 8'h10, 32'h0);
        chk_irq(1'b0);
        bus(1, 8'h10, 32'h3);
        chk_irq(1'b1);
        slow(2);
        bus(0, 8'h0C, 32'h0);
        chk_irq(1'b0);
        bus(1, 8'h00, 32'h70000 | p);
        slow(1);
        bus(0, 8'h08, 32'h2);
        slow(1);
        bus(0, 8'h08, 32'h0);
        clk_en <= 1'b0;
        slow(p);
        clk_en <= 1'b1;
        bus(0, 8'h08, 32'h0);
        idle();
        idle();
        tally_and_finish();
    end
endmodule
bind scc_seconds_counter scc_seconds_counter_asserts i_chk (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .SLOW_CLK(SLOW_CLK),
    .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
    .RD_DATA(RD_DATA), .IRQ(IRQ));
`default_nettype wire
